// >>> hw/spdif_in_pkg.sv
// Constants shared by the serial audio input stage and its line clock divider.
// Assumes a single 50 MHz core clock and an APB register bus.
package spdif_in_pkg;

  // ----------------------------------------------------------------------
  // Framing formats and word widths
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    FMT_LEFT_JUST  = 2'h0,
    FMT_I2S        = 2'h1,
    FMT_RIGHT_JUST = 2'h2
  } frame_fmt_t;

  localparam logic [1:0] WCODE_16 = 2'h0;
  localparam logic [1:0] WCODE_18 = 2'h1;
  localparam logic [1:0] WCODE_20 = 2'h2;
  localparam logic [1:0] WCODE_24 = 2'h3;

  localparam logic [5:0] WIDTH_16    = 6'h10;
  localparam logic [5:0] WIDTH_18    = 6'h12;
  localparam logic [5:0] WIDTH_20    = 6'h14;
  localparam logic [5:0] WIDTH_24    = 6'h18;
  localparam int         WORD_BITS   = 24;
  localparam logic [5:0] HALF_SLOTS  = 6'h20;
  localparam logic [5:0] SLOT_MAX    = 6'h3f;
  localparam logic [5:0] I2S_DELAY   = 6'h01;

  // ----------------------------------------------------------------------
  // Oversampling ratios; the line clock tick runs at 128 times frame rate
  // ----------------------------------------------------------------------
  localparam logic [1:0] DIV_FOR_256 = 2'h2;
  localparam logic [1:0] DIV_FOR_384 = 2'h3;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [11:0] CTRL_OFFSET   = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;
  localparam logic [11:0] LEFT_OFFSET   = 12'h008;
  localparam logic [11:0] RIGHT_OFFSET  = 12'h00c;

  localparam int CTRL_FMT_LSB   = 0;
  localparam int CTRL_WIDTH_LSB = 2;
  localparam int CTRL_RATIO_BIT = 4;
  localparam int CTRL_EN_BIT    = 5;
  localparam int STAT_LEFT_BIT  = 16;

  localparam logic [1:0] CTRL_WIDTH_RESET = WCODE_24;
  localparam logic       CTRL_RATIO_RESET = 1'b0;
  localparam logic       CTRL_EN_RESET    = 1'b0;

endpackage

// >>> hw/line_clock_divider.sv
// Divides the oversampling clock down to the biphase line clock tick.
// Assumes the oversampling clock edge arrives as a one-cycle core pulse.
module line_clock_divider (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // Oversampling edge and ratio
  input  wire logic       os_rise,
  input  wire logic       ratio_384,
  // Line clock
  output logic            line_tick,
  output logic            line_clk
);

  logic [1:0] div_cnt_reg;
  logic [1:0] div_len;

  assign div_len = ratio_384 ? spdif_in_pkg::DIV_FOR_384
                             : spdif_in_pkg::DIV_FOR_256;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_reg <= 2'h0;
      line_tick   <= 1'b0;
      line_clk    <= 1'b0;
    end else begin
      line_tick <= 1'b0;
      if (os_rise) begin
        if (div_cnt_reg >= div_len - 2'h1) begin
          div_cnt_reg <= 2'h0;
          line_tick   <= 1'b1;
          line_clk    <= ~line_clk;
        end else begin
          div_cnt_reg <= div_cnt_reg + 2'h1;
        end
      end
    end
  end

  a_div_period: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    line_tick |-> $past(div_cnt_reg) == $past(div_len) - 2'h1)
    else $error("line tick at wrong oversampling count");

  a_div_tick_cause: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    line_tick |-> $past(os_rise))
    else $error("line tick without oversampling edge");

endmodule

// >>> hw/serial_audio_input.sv
// Serial audio input stage of the digital audio transmitter, with APB slave.
// Assumes bit clock, word clock, data and oversampling clock are synchronous
// to core_clk and no faster than half its rate.
//
// Design decisions made here: the placing of the registers and the APB register port.
module serial_audio_input (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial audio source
  input  wire logic        bit_clock,
  input  wire logic        frame_sync,
  input  wire logic        serial_sample_line,
  input  wire logic        oversample_clock,
  // To the biphase encoder
  output logic [23:0]      sample_word,
  output logic             sample_left,
  output logic             sample_valid,
  output logic             line_tick,
  output logic             line_clk
);

  // ----------------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------------
  function automatic logic [5:0] width_of(input logic [1:0] code);
    case (code)
      spdif_in_pkg::WCODE_16: width_of = spdif_in_pkg::WIDTH_16;
      spdif_in_pkg::WCODE_18: width_of = spdif_in_pkg::WIDTH_18;
      spdif_in_pkg::WCODE_20: width_of = spdif_in_pkg::WIDTH_20;
      default:                width_of = spdif_in_pkg::WIDTH_24;
    endcase
  endfunction

  function automatic logic [1:0] reg_sel(input logic [11:0] addr);
    case (addr)
      spdif_in_pkg::CTRL_OFFSET:   reg_sel = 2'h0;
      spdif_in_pkg::STATUS_OFFSET: reg_sel = 2'h1;
      spdif_in_pkg::LEFT_OFFSET:   reg_sel = 2'h2;
      default:                     reg_sel = 2'h3;
    endcase
  endfunction

  function automatic logic mapped(input logic [11:0] addr);
    mapped = (addr == spdif_in_pkg::CTRL_OFFSET)
          || (addr == spdif_in_pkg::STATUS_OFFSET)
          || (addr == spdif_in_pkg::LEFT_OFFSET)
          || (addr == spdif_in_pkg::RIGHT_OFFSET);
  endfunction

  // ----------------------------------------------------------------------
  // Control and status registers
  // ----------------------------------------------------------------------
  spdif_in_pkg::frame_fmt_t fmt_reg;
  logic [1:0]               wcode_reg;
  logic                     ratio_reg;
  logic                     enable_reg;
  logic [15:0]              count_reg;
  logic [23:0]              left_reg;
  logic [23:0]              right_reg;
  logic                     ctrl_written_reg;
  logic                     access;
  logic                     wr_ctrl;

  assign access  = psel && penable && !pready;
  assign wr_ctrl = access && pwrite
                && (paddr == spdif_in_pkg::CTRL_OFFSET);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fmt_reg          <= spdif_in_pkg::FMT_I2S;
      wcode_reg        <= spdif_in_pkg::CTRL_WIDTH_RESET;
      ratio_reg        <= spdif_in_pkg::CTRL_RATIO_RESET;
      enable_reg       <= spdif_in_pkg::CTRL_EN_RESET;
      ctrl_written_reg <= 1'b0;
    end else if (wr_ctrl) begin
      ctrl_written_reg <= 1'b1;
      wcode_reg  <= pwdata[spdif_in_pkg::CTRL_WIDTH_LSB +: 2];
      ratio_reg  <= pwdata[spdif_in_pkg::CTRL_RATIO_BIT];
      enable_reg <= pwdata[spdif_in_pkg::CTRL_EN_BIT];
      case (pwdata[spdif_in_pkg::CTRL_FMT_LSB +: 2])
        2'h0:    fmt_reg <= spdif_in_pkg::FMT_LEFT_JUST;
        2'h2:    fmt_reg <= spdif_in_pkg::FMT_RIGHT_JUST;
        default: fmt_reg <= spdif_in_pkg::FMT_I2S;
      endcase
    end
  end

  a_fmt_default: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !ctrl_written_reg |-> fmt_reg == spdif_in_pkg::FMT_I2S)
    else $error("format not I2S before first control write");

  // ----------------------------------------------------------------------
  // APB answer
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= access;
      pslverr <= access && !mapped(paddr);
      prdata  <= 32'h0;
      if (access && !pwrite && mapped(paddr)) begin
        case (reg_sel(paddr))
          2'h0:    prdata <= {26'h0, enable_reg, ratio_reg, wcode_reg,
                              fmt_reg};
          2'h1:    prdata <= {15'h0, sample_left, count_reg};
          2'h2:    prdata <= {8'h0, left_reg};
          default: prdata <= {8'h0, right_reg};
        endcase
      end
    end
  end

  a_apb_answer: assert property (@(posedge core_clk) disable iff (!rst_n)
    (psel && penable && !pready) |=> pready ##1 !pready)
    else $error("APB answer not one cycle after access");

  // ----------------------------------------------------------------------
  // Bit clock edge and slot position
  // ----------------------------------------------------------------------
  logic       bclk_prev_reg;
  logic       fs_prev_reg;
  logic [5:0] slot_reg;
  logic       bit_edge;
  logic [5:0] slot_now;
  logic [5:0] width;
  logic [5:0] start_slot;
  logic [5:0] last_slot;
  logic       in_word;
  logic       left_level;

  assign bit_edge = bit_clock && !bclk_prev_reg;
  assign width    = width_of(wcode_reg);

  always_comb begin
    if (frame_sync != fs_prev_reg) begin
      slot_now = 6'h0;
    end else if (slot_reg == spdif_in_pkg::SLOT_MAX) begin
      slot_now = slot_reg;
    end else begin
      slot_now = slot_reg + 6'h1;
    end
  end

  always_comb begin
    case (fmt_reg)
      spdif_in_pkg::FMT_I2S: begin
        start_slot = spdif_in_pkg::I2S_DELAY;
        left_level = 1'b0;
      end
      spdif_in_pkg::FMT_RIGHT_JUST: begin
        start_slot = spdif_in_pkg::HALF_SLOTS - width;
        left_level = 1'b1;
      end
      default: begin
        start_slot = 6'h0;
        left_level = 1'b1;
      end
    endcase
  end

  assign last_slot = start_slot + width - 6'h1;
  assign in_word   = (slot_now >= start_slot) && (slot_now <= last_slot);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bclk_prev_reg <= 1'b0;
      fs_prev_reg   <= 1'b0;
      slot_reg      <= spdif_in_pkg::SLOT_MAX;
    end else begin
      bclk_prev_reg <= bit_clock;
      if (bit_edge) begin
        fs_prev_reg <= frame_sync;
        slot_reg    <= slot_now;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Shift in MSB first and hand the word on
  // ----------------------------------------------------------------------
  logic [23:0] shift_reg;
  logic [5:0]  got_reg;
  logic        word_done;

  assign word_done = enable_reg && bit_edge && in_word
                  && (slot_now == last_slot);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= 24'h0;
      got_reg   <= 6'h0;
    end else if (bit_edge && in_word) begin
      if (slot_now == start_slot) begin
        shift_reg <= {23'h0, serial_sample_line};
        got_reg   <= 6'h1;
      end else begin
        shift_reg <= {shift_reg[22:0], serial_sample_line};
        got_reg   <= got_reg + 6'h1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_word  <= 24'h0;
      sample_left  <= 1'b0;
      sample_valid <= 1'b0;
      left_reg     <= 24'h0;
      right_reg    <= 24'h0;
      count_reg    <= 16'h0;
    end else begin
      sample_valid <= word_done;
      if (word_done) begin
        sample_word <= {shift_reg[22:0], serial_sample_line};
        sample_left <= (frame_sync == left_level);
        count_reg   <= count_reg + 16'h1;
        if (frame_sync == left_level) begin
          left_reg <= {shift_reg[22:0], serial_sample_line};
        end else begin
          right_reg <= {shift_reg[22:0], serial_sample_line};
        end
      end
    end
  end

  a_word_bits: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    word_done |-> got_reg == width - 6'h1)
    else $error("word finished with wrong bit count");

  a_chan_level: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    word_done |=> sample_valid && sample_left == ($past(frame_sync)
      == (fmt_reg != spdif_in_pkg::FMT_I2S)))
    else $error("channel not matched to word clock level");

  a_rj_lsb_end: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (word_done && fmt_reg == spdif_in_pkg::FMT_RIGHT_JUST)
      |-> slot_now == spdif_in_pkg::HALF_SLOTS - 6'h1)
    else $error("right-justified LSB not at the last slot");

  a_msb_slot: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (bit_edge && fmt_reg == spdif_in_pkg::FMT_I2S && slot_now == 6'h1)
      |=> got_reg == 6'h1)
    else $error("I2S MSB not taken one slot after transition");

  a_valid_pulse: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    sample_valid |=> !sample_valid)
    else $error("sample valid longer than one cycle");

  // ----------------------------------------------------------------------
  // Biphase line clock
  // ----------------------------------------------------------------------
  logic os_prev_reg;
  logic os_rise;

  assign os_rise = oversample_clock && !os_prev_reg;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      os_prev_reg <= 1'b0;
    end else begin
      os_prev_reg <= oversample_clock;
    end
  end

  line_clock_divider u_div (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .os_rise   (os_rise),
    .ratio_384 (ratio_reg),
    .line_tick (line_tick),
    .line_clk  (line_clk)
  );

endmodule

// >>> testbench/audio_source_model.sv
// Behavioural serial audio source and oversampling clock for the input stage.
// Assumes core_clk clocks it; outputs change by non-blocking assignment.
module audio_source_model (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Frame request
  input  wire logic        start,
  input  wire logic [1:0]  fmt,
  input  wire logic [5:0]  wbits,
  input  wire logic [23:0] left_word,
  input  wire logic [23:0] right_word,
  // Serial link
  output logic             bit_clock,
  output logic             frame_sync,
  output logic             serial_sample_line,
  output logic             oversample_clock,
  output logic             busy
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0] phase;
  logic [6:0] slot;
  logic [6:0] rs;
  logic       lvl;
  int         msb;
  int         k;
  int         b;

  // Slot 0 is a lead-in at the right-channel level; slots 1 to 64 are real.
  assign rs  = slot - 7'h01;
  assign lvl = (fmt == spdif_in_pkg::FMT_I2S) ? 1'b0 : 1'b1;

  always_comb begin
    if (fmt == spdif_in_pkg::FMT_LEFT_JUST) msb = 0;
    else if (fmt == spdif_in_pkg::FMT_I2S) msb = 1;
    else msb = 32 - int'(wbits);
    k = int'(rs[4:0]) - msb;
    b = int'(wbits) - 1 - k;
  end

  // ----------------------------------------------------------------------
  // Bit clock stands still between frames and idle data keeps changing.
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      {bit_clock, frame_sync, serial_sample_line} <= 3'h0;
      {oversample_clock, busy, phase, slot} <= 11'h000;
    end else begin
      oversample_clock <= ~oversample_clock;
      if (!busy) begin
        serial_sample_line <= ~serial_sample_line;
        if (start) begin
          busy  <= 1'b1;
          phase <= 2'h0;
          slot  <= 7'h00;
        end
      end else begin
        phase <= phase + 2'h1;
        if (phase == 2'h0) begin
          frame_sync <= (slot == 7'h00 || rs[5]) ? ~lvl : lvl;
          if (slot != 7'h00 && k >= 0 && k < int'(wbits)) begin
            serial_sample_line <= rs[5] ? right_word[b] : left_word[b];
          end else begin
            serial_sample_line <= ~serial_sample_line;
          end
        end
        if (phase == 2'h2) bit_clock <= 1'b1;
        if (phase == 2'h3) begin
          bit_clock <= 1'b0;
          slot      <= slot + 7'h01;
          if (slot == 7'd64) busy <= 1'b0;
        end
      end
    end
  end
endmodule

// >>> testbench/spdif_tx_serial_input_tb_top.sv
// Self-checking bench for the serial audio input stage and its APB slave.
// Assumes the source model drives the serial link and oversampling clock.
module spdif_tx_serial_input_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rnd;
  logic bit_clock, frame_sync, serial_sample_line, oversample_clock;
  logic [23:0] sample_word, lw, rw, la, rb;
  logic sample_left, sample_valid, line_tick, line_clk, start, busy;
  logic [1:0]  fmt;
  logic [5:0]  wbits;
  logic [5:0]  wtab [4];
  logic [24:0] exp_q [$];
  int n_errors, checked, nsamp;

  serial_audio_input i_dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bit_clock(bit_clock), .frame_sync(frame_sync),
    .serial_sample_line(serial_sample_line),
    .oversample_clock(oversample_clock), .sample_word(sample_word),
    .sample_left(sample_left), .sample_valid(sample_valid),
    .line_tick(line_tick), .line_clk(line_clk));

  audio_source_model i_src (.core_clk(core_clk), .rst_n(rst_n), .start(start),
    .fmt(fmt), .wbits(wbits), .left_word(lw), .right_word(rw),
    .bit_clock(bit_clock), .frame_sync(frame_sync),
    .serial_sample_line(serial_sample_line),
    .oversample_clock(oversample_clock), .busy(busy));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // APB transfer: pready is sampled at rising edges; the request is held
  // until the edge that sees it high, then released at that same edge.
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic er);
    int n;
    @(posedge core_clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) chk(32'h0, 32'h1, "no pready");
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] x,
                       input logic xe, input string m);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x, m);
    chk({31'h0, e}, {31'h0, xe}, m);
  endtask

  // One frame of random left and right words; enabled frames are expected.
  task automatic frame(input logic en);
    logic [23:0] m;
    int n;
    m = 24'hffffff >> (24 - int'(wbits));
    @(posedge core_clk);
    rnd = lfsr(rnd);
    lw <= rnd[23:0];
    la = rnd[23:0] & m;
    rnd = lfsr(rnd);
    rw <= rnd[23:0];
    rb = rnd[23:0] & m;
    start <= 1'b1;
    if (en) exp_q.push_back({1'b1, la});
    if (en) exp_q.push_back({1'b0, rb});
    @(posedge core_clk);
    start <= 1'b0;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (busy !== 1'b0 && n < 400);
    repeat (4) @(posedge core_clk);
  endtask

  always @(posedge core_clk) begin
    if (sample_valid === 1'b1) begin
      if (exp_q.size() == 0) chk(32'h1, 32'h0, "extra sample");
      else chk({7'h0, sample_left, sample_word},
               {7'h0, exp_q.pop_front()}, "sample");
    end
  end

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    summarize();
  end

  initial begin
    int n, t;
    logic lc;
    {rst_n, psel, penable, pwrite, start} = 5'h00;
    {paddr, pwdata, lw, rw, fmt} = '0;
    wbits = spdif_in_pkg::WIDTH_16;
    wtab = '{spdif_in_pkg::WIDTH_16, spdif_in_pkg::WIDTH_18,
             spdif_in_pkg::WIDTH_20, spdif_in_pkg::WIDTH_24};
    rnd = 32'h5e84;
    n_errors = 0;
    checked = 0;
    nsamp = 0;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    rdchk(spdif_in_pkg::CTRL_OFFSET, 32'h0000000d, 1'b0, "ctrl");
    rdchk(12'h010, 32'h0, 1'b1, "unmapped");
    frame(1'b0);
    $display("test disabled capture done");
    for (int f = 0; f < 3; f++) begin
      for (int w = 0; w < 4; w++) begin
        wr(spdif_in_pkg::CTRL_OFFSET, 32'h0);
        fmt   <= 2'(f);
        wbits <= wtab[w];
        wr(spdif_in_pkg::CTRL_OFFSET,
           32'(f) | (32'(w) << 2) | 32'h20);
        frame(1'b1);
        frame(1'b1);
        nsamp += 4;
        rdchk(spdif_in_pkg::LEFT_OFFSET, {8'h0, la}, 1'b0, "left");
        rdchk(spdif_in_pkg::RIGHT_OFFSET, {8'h0, rb}, 1'b0, "right");
        $display("test format %0d width %0d done", f, wtab[w]);
      end
    end
    rdchk(spdif_in_pkg::STATUS_OFFSET, {16'h0, 16'(nsamp)}, 1'b0, "status");
    wr(spdif_in_pkg::STATUS_OFFSET, 32'hffffffff);
    rdchk(spdif_in_pkg::STATUS_OFFSET, {16'h0, 16'(nsamp)}, 1'b0, "status");
    $display("test registers done");
    for (int r = 0; r < 2; r++) begin
      wr(spdif_in_pkg::CTRL_OFFSET, 32'(r) << 4);
      n = 0;
      t = 0;
      lc = line_clk;
      repeat (384) begin
        @(posedge core_clk);
        if (line_tick === 1'b1) n++;
        if (line_clk !== lc) t++;
        lc = line_clk;
      end
      chk(32'(t), 32'(n), "line clock toggles");
      // Oversampling edges come every two cycles: 192 here, divided by 2 or 3.
      n = n - ((r == 1) ? 64 : 96);
      chk(32'(n >= -1 && n <= 1), 32'h1, "line tick rate");
      $display("test line clock ratio %0d done", r);
    end
    chk(32'(exp_q.size()), 32'h0, "missing samples");
    summarize();
  end
endmodule
